// file: core/lest_trigger.sv
`timescale 1ns/10ps
// Operation
// [R1] After start, read the level once per minute as the tracked level.
// [R2] Start reads the level at once, with no further action.
// [R3] Storm mode waits for level one, then samples and starts override one.
// [R4] Once armed, any sampling level reached triggers a sample.
// [R5] Once armed, a rise or fall by the delta triggers a sample.
// [R6] Expired override with no other event triggers a sample.
// [R7] Only level match, delta and override expiry start a storm sample.
// [R8] Each trigger commands advance, collect, deposit, to successive bottles.
// [R9] Stop when all bottles hold a sample or a bottle is full.
// [R10] Level or delta samples reload the override to full duration.
// [R11] Every sample, override ones too, restarts the override.
// [R12] Each level has its own override; only the current band's runs. Code: bands four and five both use override four.
// [R13] Override four takes effect from the band of level five on.
// [R14] One rising and one falling delta held for the whole run.
// [R15] Upper limit is full span, lower limit zero; span is their difference.
// [R16] Span quantised into 256 steps; comparisons on step multiples.
// [R17] An unaligned entry yields the nearest aligned proposal.
// [R18] Storm mode takes at most six levels; entry may end early.
// [R19] Analog mode takes up to 32 rising levels; entry may end early.
// [R20] Level one must lie strictly above the lower limit.
// [R21] Limits and levels are four-digit values with one common scaling.
// [R22] A top level equal to the upper limit is its own entry.
// [R23] Above upper reads as highest level; below lower clamps to lower.
// [R24] Delta fires when the change equals or exceeds the delta.
// [R25] Overrides held as hours and minutes, counted from reaching the level.
// [R26] Step code 0 at lower limit, 255 at upper limit.
// [R27] Override counts down per minute tick and expires at zero.
module lest_trigger
   import lest_pkg::*;
#(
   parameter logic [35:0] MIN_CYC = 36'(MINUTE_CYC)
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // APB slave
   input wire lest_apb_req_t apb_req,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Level transmitter and sequencer pins
   input wire logic [RAW_W-1:0] level_in,
   input wire logic step_done,
   input wire logic bottle_full,
   // Sequencer command
   output lest_seq_cmd_t seq_cmd
);

   // ==========================================================
   // Declarations
   logic [RAW_W-1:0] upper_r, lower_r, rise_r, fall_r, probe_r;
   logic [5:0] nlvl_r;
   logic [7:0] bottles_r;
   logic storm_r, running_r, start_r;
   logic [CODE_W-1:0] lvl_r [MAX_LVL_ANALOG];
   logic [15:0] ovr_r [N_OVR];
   logic [RAW_W-1:0] lvl_s1_r, lvl_s2_r, lvl_s3_r, lvl_stable_r;
   logic [2:0] done_sync_r, full_sync_r;
   logic done_stable_r, done_prev_r, full_stable_r;
   logic [35:0] min_cnt_r;
   logic tick_r, eval_r, trig_r, armed_r, pend_r, done_r;
   logic [CODE_W-1:0] code_r, ref_r;
   logic [5:0] band_r;
   logic [OVR_W-1:0] ovr_cnt_r;
   logic [7:0] bottle_cnt_r;
   lest_seq_state_t seq_state_r;
   logic [31:0] rd_data;
   logic wr_err, rd_err;
   logic [5:0] band_now;
   logic [CODE_W-1:0] rise_code, fall_code, entry_code, acq_code;
   logic done_edge;

   // ==========================================================
   // Arithmetic helpers
   // Step code of a value; rounds to the nearest step and clamps to the span
   function automatic logic [CODE_W-1:0] to_code(input logic [RAW_W-1:0] v, input logic [RAW_W-1:0] lo,
                                                 input logic [RAW_W-1:0] hi);
      logic [RAW_W+STEP_SHIFT:0] num;
      logic [RAW_W+STEP_SHIFT:0] q;
      logic [RAW_W-1:0] span;
      span = hi - lo;
      num = '0;
      q = '0;
      if (v <= lo) begin
         to_code = '0;
      end else if (v >= hi) begin
         to_code = CODE_MAX;
      end else begin
         num = ({(RAW_W+STEP_SHIFT+1)'(v - lo)} << STEP_SHIFT) + (RAW_W+STEP_SHIFT+1)'(span >> 1);
         q = num / (RAW_W+STEP_SHIFT+1)'(span);
         to_code = (q > (RAW_W+STEP_SHIFT+1)'(CODE_MAX)) ? CODE_MAX : q[CODE_W-1:0];
      end
   endfunction

   // Number of whole steps in a level difference, rounded to nearest
   function automatic logic [CODE_W-1:0] to_steps(input logic [RAW_W-1:0] d, input logic [RAW_W-1:0] span);
      logic [RAW_W+STEP_SHIFT:0] q;
      q = (({(RAW_W+STEP_SHIFT+1)'(d)} << STEP_SHIFT) + (RAW_W+STEP_SHIFT+1)'(span >> 1))
          / (RAW_W+STEP_SHIFT+1)'(span);
      to_steps = (q > (RAW_W+STEP_SHIFT+1)'(CODE_MAX)) ? CODE_MAX : q[CODE_W-1:0];
   endfunction

   // Value in level units that a step code stands for
   function automatic logic [RAW_W-1:0] from_code(input logic [CODE_W-1:0] c, input logic [RAW_W-1:0] lo,
                                                  input logic [RAW_W-1:0] hi);
      logic [RAW_W+CODE_W-1:0] p;
      p = (RAW_W+CODE_W)'(c) * (RAW_W+CODE_W)'(hi - lo) + (RAW_W+CODE_W)'(1 << (STEP_SHIFT - 1));
      from_code = lo + p[RAW_W+STEP_SHIFT-1:STEP_SHIFT];
   endfunction

   // Override duration in minutes from hours and minutes
   function automatic logic [OVR_W-1:0] ovr_minutes(input logic [15:0] hm);
      ovr_minutes = OVR_W'(hm[15:OVR_HOUR_LSB]) * MIN_PER_HOUR + OVR_W'(hm[OVR_HOUR_LSB-1:0]); // [R25]
   endfunction

   // Override that belongs to a band; from the fifth level band the numbering lags by one
   function automatic logic [2:0] ovr_index(input logic [5:0] band);
      if (band >= 6'd5) begin
         ovr_index = 3'(band - 6'd2); // [R13]
      end else if (band == 6'd0) begin
         ovr_index = 3'd0;
      end else begin
         ovr_index = 3'(band - 6'd1); // [R12]
      end
   endfunction

   // ==========================================================
   // Combinational decode
   always_comb begin
      band_now = '0;
      for (int i = 0; i < MAX_LVL_ANALOG; i++) begin
         if (6'(i) < nlvl_r && code_r >= lvl_r[i]) begin
            band_now = 6'(i + 1); // [R4] [R16]
         end
      end
   end

   assign rise_code = to_steps(rise_r, upper_r - lower_r); // [R14]
   assign fall_code = to_steps(fall_r, upper_r - lower_r); // [R14]
   assign entry_code = to_code(apb_req.pwdata[RAW_W-1:0], lower_r, upper_r); // [R26]
   assign done_edge = done_stable_r && !done_prev_r;

   // Above the upper limit the level sits at the highest programmed level
   always_comb begin
      if (lvl_stable_r > upper_r && nlvl_r != 6'd0) begin
         acq_code = lvl_r[5'(nlvl_r - 6'd1)]; // [R23]
      end else begin
         acq_code = to_code(lvl_stable_r, lower_r, upper_r); // [R15] [R23] [R26]
      end
   end

   // ==========================================================
   // APB decode
   always_comb begin
      rd_data = '0;
      rd_err = 1'b0;
      if (apb_req.paddr[11:7] == REGION_LVL) begin
         rd_data[CODE_W-1:0] = lvl_r[apb_req.paddr[6:2]];
      end else if (apb_req.paddr[11:7] == REGION_OVR && apb_req.paddr[6:2] < 5'(N_OVR)) begin
         rd_data[15:0] = ovr_r[3'(apb_req.paddr[6:2])];
      end else begin
         case (apb_req.paddr)
            OFS_CTRL: rd_data[CTRL_STORM_BIT] = storm_r;
            OFS_STATUS: begin
               rd_data[ST_RUN_BIT] = running_r;
               rd_data[ST_ARMED_BIT] = armed_r;
               rd_data[ST_DONE_BIT] = done_r;
               rd_data[ST_BUSY_BIT] = (seq_state_r != SEQ_IDLE);
               rd_data[ST_FULL_BIT] = full_stable_r;
               rd_data[ST_CODE_LSB +: CODE_W] = code_r;
               rd_data[ST_BAND_LSB +: 6] = band_r;
               rd_data[ST_BOTTLE_LSB +: 8] = bottle_cnt_r;
            end
            OFS_UPPER: rd_data[RAW_W-1:0] = upper_r;
            OFS_LOWER: rd_data[RAW_W-1:0] = lower_r;
            OFS_RISE: rd_data[RAW_W-1:0] = rise_r;
            OFS_FALL: rd_data[RAW_W-1:0] = fall_r;
            OFS_NLVL: rd_data[5:0] = nlvl_r;
            OFS_BOTTLES: rd_data[7:0] = bottles_r;
            OFS_PROBE: rd_data[RAW_W-1:0] = probe_r;
            OFS_PROPOSAL: rd_data[RAW_W-1:0] = from_code(to_code(probe_r, lower_r, upper_r), lower_r, upper_r); // [R17]
            default: rd_err = 1'b1;
         endcase
      end
   end

   // Write checks; configuration is frozen while a program runs
   always_comb begin
      logic [RAW_W-1:0] v;
      logic [4:0] idx;
      v = apb_req.pwdata[RAW_W-1:0];
      idx = apb_req.paddr[6:2];
      wr_err = rd_err;
      if (apb_req.paddr[11:7] == REGION_LVL) begin
         if (running_r || 6'(idx) >= nlvl_r || v > RAW_MAX) begin
            wr_err = 1'b1;
         end else if (idx == 5'd0) begin
            wr_err = (v <= lower_r) || (entry_code == '0); // [R20]
         end else begin
            wr_err = (entry_code <= lvl_r[5'(idx - 5'd1)]); // [R19]
         end
      end else if (apb_req.paddr[11:7] == REGION_OVR) begin
         wr_err = rd_err || running_r || apb_req.pwdata[OVR_HOUR_LSB-1:0] >= 8'(MIN_PER_HOUR);
      end else if (apb_req.paddr != OFS_CTRL && apb_req.paddr != OFS_PROBE && running_r) begin
         wr_err = 1'b1;
      end else begin
         case (apb_req.paddr)
            OFS_UPPER: wr_err = (v > RAW_MAX) || (v <= lower_r); // [R21]
            OFS_LOWER: wr_err = (v >= upper_r); // [R21]
            OFS_NLVL: wr_err = (apb_req.pwdata[5:0] == 6'd0) ||
                               (apb_req.pwdata[5:0] > (storm_r ? 6'(MAX_LVL_STORM) : 6'(MAX_LVL_ANALOG))); // [R18] [R19]
            OFS_STATUS, OFS_PROPOSAL: wr_err = 1'b1;
            default: ;
         endcase
      end
   end

   // ==========================================================
   // APB slave and registers: one wait state, write lands at the completing edge
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pready <= 1'b0;
         prdata <= '0;
         pslverr <= 1'b0;
         upper_r <= UPPER_RST;
         lower_r <= LOWER_RST;
         rise_r <= DELTA_RST;
         fall_r <= DELTA_RST;
         probe_r <= LOWER_RST;
         nlvl_r <= NLVL_RST;
         bottles_r <= BOTTLES_RST;
         storm_r <= 1'b0;
         running_r <= 1'b0;
         start_r <= 1'b0;
         for (int i = 0; i < MAX_LVL_ANALOG; i++) begin
            lvl_r[i] <= '0;
         end
         for (int i = 0; i < N_OVR; i++) begin
            ovr_r[i] <= '0;
         end
      end else begin
         start_r <= 1'b0;
         if (done_r && !start_r) begin
            running_r <= 1'b0; // [R9]
         end
         if (apb_req.psel && apb_req.penable && !pready) begin
            pready <= 1'b1;
            prdata <= apb_req.pwrite ? 32'h0000_0000 : rd_data;
            pslverr <= apb_req.pwrite ? wr_err : rd_err;
         end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
         end
         if (apb_req.psel && apb_req.penable && pready && apb_req.pwrite && !pslverr) begin
            if (apb_req.paddr[11:7] == REGION_LVL) begin
               lvl_r[apb_req.paddr[6:2]] <= entry_code; // [R16] [R22]
            end else if (apb_req.paddr[11:7] == REGION_OVR) begin
               ovr_r[3'(apb_req.paddr[6:2])] <= apb_req.pwdata[15:0]; // [R25]
            end else begin
               case (apb_req.paddr)
                  OFS_CTRL: begin
                     if (apb_req.pwdata[CTRL_STOP_BIT]) begin
                        running_r <= 1'b0;
                     end else if (apb_req.pwdata[CTRL_START_BIT] && !running_r && nlvl_r != 6'd0) begin
                        running_r <= 1'b1;
                        start_r <= 1'b1;
                     end
                     if (!running_r) begin
                        storm_r <= apb_req.pwdata[CTRL_STORM_BIT];
                     end
                  end
                  OFS_UPPER: upper_r <= apb_req.pwdata[RAW_W-1:0];
                  OFS_LOWER: lower_r <= apb_req.pwdata[RAW_W-1:0];
                  OFS_RISE: rise_r <= apb_req.pwdata[RAW_W-1:0];
                  OFS_FALL: fall_r <= apb_req.pwdata[RAW_W-1:0];
                  OFS_NLVL: nlvl_r <= apb_req.pwdata[5:0];
                  OFS_BOTTLES: bottles_r <= apb_req.pwdata[7:0];
                  OFS_PROBE: probe_r <= apb_req.pwdata[RAW_W-1:0];
                  default: ;
               endcase
            end
         end
      end
   end

   // ==========================================================
   // Pin synchronisers; a change counts once the second and third stages agree
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         lvl_s1_r <= '0;
         lvl_s2_r <= '0;
         lvl_s3_r <= '0;
         lvl_stable_r <= '0;
         done_sync_r <= '0;
         full_sync_r <= '0;
         done_stable_r <= 1'b0;
         done_prev_r <= 1'b0;
         full_stable_r <= 1'b0;
      end else begin
         lvl_s1_r <= level_in;
         lvl_s2_r <= lvl_s1_r;
         lvl_s3_r <= lvl_s2_r;
         if (lvl_s2_r == lvl_s3_r) begin
            lvl_stable_r <= lvl_s3_r;
         end
         done_sync_r <= {done_sync_r[1:0], step_done};
         full_sync_r <= {full_sync_r[1:0], bottle_full};
         if (done_sync_r[1] == done_sync_r[2]) begin
            done_stable_r <= done_sync_r[2];
         end
         if (full_sync_r[1] == full_sync_r[2]) begin
            full_stable_r <= full_sync_r[2];
         end
         done_prev_r <= done_stable_r;
      end
   end

   // ==========================================================
   // Minute divider and level acquisition
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         min_cnt_r <= '0;
         tick_r <= 1'b0;
         eval_r <= 1'b0;
         code_r <= '0;
      end else begin
         tick_r <= 1'b0;
         eval_r <= tick_r;
         if (start_r) begin
            min_cnt_r <= '0;
            tick_r <= 1'b1; // [R2]
         end else if (running_r) begin
            if (min_cnt_r >= MIN_CYC - 36'd1) begin
               min_cnt_r <= '0;
               tick_r <= 1'b1; // [R1]
            end else begin
               min_cnt_r <= min_cnt_r + 36'd1;
            end
         end
         if (tick_r) begin
            code_r <= acq_code; // [R1]
         end
      end
   end

   // ==========================================================
   // Trigger evaluation, one cycle after each acquisition
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         trig_r <= 1'b0;
         armed_r <= 1'b0;
         band_r <= '0;
         ref_r <= '0;
         ovr_cnt_r <= '0;
      end else if (start_r) begin
         trig_r <= 1'b0;
         armed_r <= 1'b0;
         band_r <= '0;
         ref_r <= '0;
         ovr_cnt_r <= '0;
      end else begin
         trig_r <= 1'b0;
         if (tick_r && running_r && armed_r && ovr_cnt_r != '0) begin
            ovr_cnt_r <= ovr_cnt_r - OVR_W'(1); // [R27]
         end
         if (eval_r && running_r && !done_r) begin
            if (storm_r) begin
               if (!armed_r) begin
                  if (code_r >= lvl_r[0]) begin
                     armed_r <= 1'b1; // [R3]
                     trig_r <= 1'b1;
                     band_r <= band_now;
                     ref_r <= code_r;
                     ovr_cnt_r <= ovr_minutes(ovr_r[ovr_index(band_now)]); // [R3] [R12]
                  end
               end else if ((band_now != band_r) || // [R4] [R7]
                            (code_r >= ref_r && (code_r - ref_r) >= rise_code) || // [R5] [R24]
                            (code_r < ref_r && (ref_r - code_r) >= fall_code) || // [R5] [R24]
                            (ovr_cnt_r == '0)) begin // [R6] [R27]
                  trig_r <= 1'b1;
                  band_r <= band_now;
                  ref_r <= code_r;
                  // Reload from the band now occupied, full duration
                  ovr_cnt_r <= ovr_minutes(ovr_r[ovr_index(band_now)]); // [R10] [R11] [R12]
               end
            end else if (band_now != band_r) begin
               trig_r <= 1'b1; // [R19]
               band_r <= band_now;
            end
         end
      end
   end

   // ==========================================================
   // Sample sequencer; a trigger during a sequence waits in one pending slot
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         seq_state_r <= SEQ_IDLE;
         seq_cmd <= '0;
         pend_r <= 1'b0;
         done_r <= 1'b0;
         bottle_cnt_r <= '0;
      end else if (start_r) begin
         seq_state_r <= SEQ_IDLE;
         seq_cmd <= '0;
         pend_r <= 1'b0;
         done_r <= 1'b0;
         bottle_cnt_r <= '0;
      end else begin
         seq_cmd.advance <= 1'b0;
         seq_cmd.collect <= 1'b0;
         seq_cmd.deposit <= 1'b0;
         seq_cmd.bottle <= bottle_cnt_r;
         if (full_stable_r && running_r) begin
            done_r <= 1'b1; // [R9]
         end
         case (seq_state_r)
            SEQ_IDLE: begin
               if (pend_r && running_r && !done_r && !full_stable_r) begin
                  pend_r <= 1'b0;
                  seq_cmd.advance <= 1'b1; // [R8]
                  seq_state_r <= SEQ_ADV;
               end
            end
            SEQ_ADV: begin
               if (done_edge) begin
                  seq_cmd.collect <= 1'b1; // [R8]
                  seq_state_r <= SEQ_COLLECT;
               end
            end
            SEQ_COLLECT: begin
               if (done_edge) begin
                  seq_cmd.deposit <= 1'b1; // [R8]
                  seq_state_r <= SEQ_DEPOSIT;
               end
            end
            SEQ_DEPOSIT: begin
               if (done_edge) begin
                  bottle_cnt_r <= bottle_cnt_r + 8'd1; // [R8]
                  if (bottle_cnt_r + 8'd1 >= bottles_r) begin
                     done_r <= 1'b1; // [R9]
                  end
                  seq_state_r <= SEQ_IDLE;
               end
            end
            default: seq_state_r <= SEQ_IDLE;
         endcase
         // A new trigger wins over the clear above
         if (trig_r) begin
            pend_r <= 1'b1; // [R8]
         end
      end
   end

endmodule

// file: core/lest_pkg.sv
package lest_pkg;

   // ==========================================================
   // Timing
   localparam longint unsigned CLK_HZ = 125_000_000;
   localparam longint unsigned MINUTE_S = 60;
   localparam longint unsigned MINUTE_CYC = MINUTE_S * CLK_HZ;

   // ==========================================================
   // Value widths and limits
   localparam int RAW_W = 14;
   localparam int CODE_W = 8;
   localparam int STEP_SHIFT = 8;
   localparam logic [CODE_W-1:0] CODE_MAX = 8'hff;
   localparam logic [RAW_W-1:0] RAW_MAX = 14'h270f;
   localparam int MAX_LVL_ANALOG = 32;
   localparam int MAX_LVL_STORM = 6;
   localparam int N_OVR = 6;
   localparam int OVR_W = 13;
   localparam logic [OVR_W-1:0] MIN_PER_HOUR = 13'h003c;

   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_STATUS = 12'h004;
   localparam logic [11:0] OFS_UPPER = 12'h008;
   localparam logic [11:0] OFS_LOWER = 12'h00c;
   localparam logic [11:0] OFS_RISE = 12'h010;
   localparam logic [11:0] OFS_FALL = 12'h014;
   localparam logic [11:0] OFS_NLVL = 12'h018;
   localparam logic [11:0] OFS_BOTTLES = 12'h01c;
   localparam logic [11:0] OFS_PROBE = 12'h020;
   localparam logic [11:0] OFS_PROPOSAL = 12'h024;
   localparam logic [4:0] REGION_LVL = 5'h02;
   localparam logic [4:0] REGION_OVR = 5'h03;

   // ==========================================================
   // Field positions
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_STOP_BIT = 1;
   localparam int CTRL_STORM_BIT = 2;
   localparam int ST_RUN_BIT = 0;
   localparam int ST_ARMED_BIT = 1;
   localparam int ST_DONE_BIT = 2;
   localparam int ST_BUSY_BIT = 3;
   localparam int ST_FULL_BIT = 4;
   localparam int ST_CODE_LSB = 8;
   localparam int ST_BAND_LSB = 16;
   localparam int ST_BOTTLE_LSB = 24;
   localparam int OVR_HOUR_LSB = 8;

   // ==========================================================
   // Reset values
   localparam logic [RAW_W-1:0] UPPER_RST = 14'h03e8;
   localparam logic [RAW_W-1:0] LOWER_RST = 14'h0000;
   localparam logic [RAW_W-1:0] DELTA_RST = 14'h000a;
   localparam logic [5:0] NLVL_RST = 6'h00;
   localparam logic [7:0] BOTTLES_RST = 8'h18;

   // ==========================================================
   // Types
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } lest_apb_req_t;

   typedef struct packed {
      logic advance;
      logic collect;
      logic deposit;
      logic [7:0] bottle;
   } lest_seq_cmd_t;

   typedef enum logic [1:0] {SEQ_IDLE, SEQ_ADV, SEQ_COLLECT, SEQ_DEPOSIT} lest_seq_state_t;

endpackage

// file: test/lest_trigger_sva.sv
`timescale 1ns/10ps
module lest_trigger_sva
   import lest_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // APB
   input wire lest_apb_req_t apb_req,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pins
   input wire logic [RAW_W-1:0] level_in,
   input wire logic step_done,
   input wire logic bottle_full,
   input wire lest_seq_cmd_t seq_cmd
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   logic any_cmd;
   assign any_cmd = seq_cmd.advance | seq_cmd.collect | seq_cmd.deposit;
   sequence s_take;
      apb_req.psel && apb_req.penable && !pready;
   endsequence
   // A step cannot finish faster than the step_done synchroniser
   sequence s_quiet;
      !any_cmd [*4];
   endsequence
   a_ready_wait: assert property (s_take |=> pready) else $error("pready late");
   a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
   a_ready_cause: assert property (pready |-> $past(apb_req.psel && apb_req.penable)) else $error("pready no cause");
   a_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
   a_cmd_single: assert property ($onehot0({seq_cmd.advance, seq_cmd.collect, seq_cmd.deposit}))
      else $error("two commands");
   a_step_gap: assert property (any_cmd |=> s_quiet) else $error("command too soon");
   a_full_block: assert property (bottle_full [*6] |-> !seq_cmd.advance) else $error("advance when full");
   a_bottle_step: assert property ($changed(seq_cmd.bottle) |->
      (seq_cmd.bottle == $past(seq_cmd.bottle) + 8'h01) || (seq_cmd.bottle == 8'h00)) else $error("bottle jump");
   a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> !pready && !any_cmd) else $error("busy in reset");
endmodule
bind lest_trigger lest_trigger_sva lest_trigger_sva_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .apb_req(apb_req),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .level_in(level_in), .step_done(step_done),
   .bottle_full(bottle_full), .seq_cmd(seq_cmd));

// file: test/lest_far_model.sv
`timescale 1ns/10ps
module lest_far_model
   import lest_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Sequencer side
   input wire lest_seq_cmd_t seq_cmd,
   input wire logic [3:0] dly,
   output logic step_done
);
   logic [4:0] cnt_r;
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cnt_r <= 5'h00;
      end else if (seq_cmd.advance | seq_cmd.collect | seq_cmd.deposit) begin
         cnt_r <= {1'b0, dly} + 5'h08;
      end else if (cnt_r != 5'h00) begin
         cnt_r <= cnt_r - 5'h01;
      end
   end
   // Held four cycles so the three-flop sync sees a stable high
   assign step_done = (cnt_r != 5'h00) && (cnt_r <= 5'h04);
endmodule

// file: test/lest_trigger_tb.sv
`timescale 1ns/10ps
module lest_trigger_tb
   import lest_pkg::*;
;
   localparam logic [11:0] LV0 = 12'h100;
   localparam logic [11:0] LV1 = 12'h104;
   localparam logic [11:0] OV0 = 12'h180;
   localparam logic [11:0] OV1 = 12'h184;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   lest_apb_req_t req = '0;
   logic [RAW_W-1:0] level_in = 14'h0000;
   logic full_in = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, step_done;
   lest_seq_cmd_t seq_cmd;
   int error_cnt = 0;
   int cmp_count = 0;
   int adv_n = 0;
   int dep_n = 0;
   logic [31:0] rd;
   logic er;
   initial forever #4 ref_clk = ~ref_clk;
   // Minute shortened to 20 cycles
   lest_trigger #(.MIN_CYC(36'h0_0000_0014)) lest_trigger_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .apb_req(req), .prdata(prdata), .pready(pready), .pslverr(pslverr), .level_in(level_in),
      .step_done(step_done), .bottle_full(full_in), .seq_cmd(seq_cmd));
   lest_far_model lest_far_model_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .seq_cmd(seq_cmd),
      .dly(4'h2), .step_done(step_done));
   // ==========================================
   // Checks and bus tasks
   task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, exp, got);
      end
   endtask
   task give_verdict;
      $display("errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge ref_clk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge ref_clk);
      req.penable <= 1'b1;
      i = 0;
      do begin
         @(posedge ref_clk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (pready !== 1'b1) begin
         error_cnt++;
         give_verdict;
      end
      rd = prdata;
      er = pslverr;
      req <= '0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d, input logic e);
      apb(1'b1, a, d);
      chk("pslverr", 32'(e), 32'(er));
   endtask
   task wait_dep(input int n);
      int i;
      for (i = 0; i < 4000 && dep_n < n; i++) @(posedge ref_clk);
      if (dep_n < n) begin
         error_cnt++;
         give_verdict;
      end
   endtask
   always @(posedge ref_clk) begin
      if (seq_cmd.advance === 1'b1) adv_n <= adv_n + 1;
      if (seq_cmd.deposit === 1'b1) begin
         chk("bottle", 32'(dep_n % 3), {24'h00_0000, seq_cmd.bottle});
         dep_n <= dep_n + 1;
      end
   end
   // ==========================================
   // Scenarios
   task t_config;
      apb(1'b0, OFS_UPPER, 32'h0000_0000);
      chk("upper", 32'(UPPER_RST), rd);
      wr(OFS_CTRL, 32'h0000_0004, 1'b0);
      wr(OFS_NLVL, 32'h0000_0007, 1'b1);
      wr(OFS_NLVL, 32'h0000_0002, 1'b0);
      wr(LV0, 32'h0000_0000, 1'b1);
      wr(LV0, 32'h0000_01f4, 1'b0);
      wr(LV1, 32'h0000_0190, 1'b1);
      wr(LV1, 32'h0000_02ee, 1'b0);
      apb(1'b0, LV0, 32'h0000_0000);
      chk("level0", 32'h0000_0080, rd);
      wr(OV0, 32'h0000_003c, 1'b1);
      wr(OV0, 32'h0000_0001, 1'b0);
      wr(OV1, 32'h0000_0001, 1'b0);
      wr(12'h040, 32'h0000_0000, 1'b1);
      wr(OFS_BOTTLES, 32'h0000_0003, 1'b0);
      wr(OFS_RISE, 32'h0000_012c, 1'b0);
      wr(OFS_FALL, 32'h0000_012c, 1'b0);
   endtask
   task t_storm;
      level_in <= 14'h0064;
      wr(OFS_CTRL, 32'h0000_0005, 1'b0);
      repeat (120) @(posedge ref_clk);
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
      chk("status", 32'h0000_1a01, rd & 32'hff3f_ff1f);
      chk("advances", 32'h0000_0000, 32'(adv_n));
      level_in <= 14'h01f4;
      // Level stays put: samples after arming come only from override expiry
      wait_dep(3);
      repeat (100) @(posedge ref_clk);
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
      chk("status", 32'h0301_8006, rd & 32'hff3f_ff1f);
      chk("deposits", 32'h0000_0003, 32'(dep_n));
      wr(OFS_STATUS, 32'h0000_0000, 1'b1);
   endtask
   task t_rerun;
      full_in <= 1'b1;
      wr(OFS_CTRL, 32'h0000_0005, 1'b0);
      repeat (60) @(posedge ref_clk);
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
      chk("status", 32'h0000_8014, rd & 32'hff3f_ff1f);
      full_in <= 1'b0;
      wr(OFS_CTRL, 32'h0000_0001, 1'b0);
      wait_dep(4);
      level_in <= 14'h0064;
      wait_dep(5);
      chk("advances", 32'h0000_0005, 32'(adv_n));
   endtask
   initial begin
      repeat (8) @(posedge ref_clk);
      sys_rst <= 1'b0;
      t_config;
      t_storm;
      t_rerun;
      give_verdict;
   end
endmodule
